// >>> tdio_top.v
`timescale 1ns/1ps
`include "tdio_defs.vh"
module tdio_top #(
    parameter NCH = 32,
    parameter GRP = 8,
    parameter DEPTH = `TDIO_FIFO_DEPTH
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire [7:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    input wire [NCH-1:0] dio_in,
    output reg [NCH-1:0] dio_out,
    output reg [NCH-1:0] dio_oe_out,
    input wire event_in,
    output reg irq_out
);
    localparam NG = NCH / GRP;
    localparam [8:0] ACC_STEP = `TDIO_SAMPLE_MHZ;
    localparam [8:0] ACC_WRAP = `TDIO_CLK_MHZ;
    // Phase accumulator, not a divider: ticks are 2 or 3 cycles apart
    // but average exactly the sample rate instead of rounding it
    localparam ST_IDLE = 3'b001;
    localparam ST_ACK = 3'b010;
    localparam ST_DONE = 3'b100;

    // ------------------------------------------------------------
    // Input sampling
    // ------------------------------------------------------------
    wire [NCH-1:0] din_s;
    wire ev_s;
    tdio_sync3 #(.W(NCH)) u_sync_d (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .d_in(dio_in),
        .q_out(din_s)
    );
    tdio_sync3 #(.W(1)) u_sync_e (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .d_in(event_in),
        .q_out(ev_s)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    reg [NG-1:0] dir_r;
    reg [NCH-1:0] stage_r;
    reg en_r;
    reg mode_r;
    reg start_r;
    reg [31:0] time_r;
    reg [7:0] div_r;
    reg [NCH-1:0] prev_r;
    reg [NCH-1:0] rise_r;
    reg [NCH-1:0] fall_r;
    reg [NCH-1:0] latin_r;
    reg [NCH-1:0] latout_r;
    reg ev_d_r;
    reg [3:0] ist_r;
    reg [3:0] ien_r;
    reg [2:0] st_r;
    reg [31:0] hold_r;
    reg full_d_r;
    reg empty_d_r;
    reg fclr_r;
    reg wr_r;
    reg [63:0] wdat_r;
    reg rd_r;

    wire [63:0] f_rdata;
    wire f_full;
    wire f_empty;
    wire [9:0] f_cnt;
    wire [8:0] acc_sum = {1'b0, div_r} + ACC_STEP;
    wire tick = (acc_sum >= ACC_WRAP);
    wire [8:0] div_nxt = tick ? acc_sum - ACC_WRAP : acc_sum;
    wire [NCH-1:0] dir_mask;
    wire sel = (st_r == ST_IDLE) && (avs_read_in || avs_write_in);
    wire wsel = sel && avs_write_in;
    wire rsel = sel && avs_read_in;
    wire [31:0] wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                         {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    wire due;
    wire rec_wr;
    wire out_rd;
    wire host_rd;
    wire [3:0] ev_set;

    genvar g;
    generate
        for (g = 0; g < NG; g = g + 1) begin : gdir
            assign dir_mask[g*GRP +: GRP] = {GRP{dir_r[g]}};
        end
    endgenerate

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [31:0] m;
        begin
            merge = (old & ~m) | (nw & m);
        end
    endfunction
    wire [31:0] dir_wr = merge({28'h0, dir_r}, avs_writedata_in, wmask);

    tdio_fifo #(.DW(64), .DEPTH(DEPTH), .AW(9)) u_fifo (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .clr_in(fclr_r),
        .wr_in(wr_r),
        .wdata_in(wdat_r),
        .rd_in(rd_r),
        .rdata_out(f_rdata),
        .full_out(f_full),
        .empty_out(f_empty),
        .count_out(f_cnt)
    );

    // ------------------------------------------------------------
    // Recording and schedule
    // ------------------------------------------------------------
    assign rec_wr = en_r && !mode_r && tick && ((din_s & ~dir_mask) != prev_r);
    assign due = en_r && mode_r && start_r && !f_empty && !rd_r &&
                 (f_rdata[63:32] == time_r);
    assign out_rd = due;
    assign host_rd = rsel && (avs_address_in == `TDIO_A_FTIME) && !mode_r && !f_empty;
    assign ev_set[`TDIO_I_EVENT] = ev_s && !ev_d_r;
    assign ev_set[`TDIO_I_FULL] = f_full && !full_d_r && !mode_r;
    assign ev_set[`TDIO_I_EMPTY] = f_empty && !empty_d_r && mode_r;
    assign ev_set[`TDIO_I_EDGE] = rec_wr;

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            div_r <= 8'h00;
            time_r <= 32'h0000_0000;
            prev_r <= {NCH{1'b0}};
            rise_r <= {NCH{1'b0}};
            fall_r <= {NCH{1'b0}};
            wr_r <= 1'b0;
            wdat_r <= 64'h0000_0000_0000_0000;
            rd_r <= 1'b0;
            ev_d_r <= 1'b0;
            full_d_r <= 1'b0;
            empty_d_r <= 1'b1;
            ist_r <= 4'h0;
            irq_out <= 1'b0;
            dio_out <= {NCH{1'b0}};
            dio_oe_out <= {NCH{1'b0}};
        end else begin
            div_r <= div_nxt[7:0];
            time_r <= time_r + 32'h0000_0001;
            ev_d_r <= ev_s;
            full_d_r <= f_full;
            empty_d_r <= f_empty;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            if (tick) begin
                prev_r <= din_s & ~dir_mask;
            end
            if (rec_wr) begin
                wr_r <= 1'b1;
                wdat_r <= {time_r, din_s & ~dir_mask};
            end else if (wsel && avs_address_in == `TDIO_A_FTIME && mode_r) begin
                wr_r <= 1'b1;
                wdat_r <= {avs_writedata_in, hold_r};
            end
            if (out_rd || host_rd) begin
                rd_r <= 1'b1;
            end
            // Set wins over clear
            if (wsel && avs_address_in == `TDIO_A_RISE) begin
                rise_r <= (rise_r & ~avs_writedata_in) | (din_s & ~prev_r & ~dir_mask);
            end else if (tick) begin
                rise_r <= rise_r | (din_s & ~prev_r & ~dir_mask);
            end
            if (wsel && avs_address_in == `TDIO_A_FALL) begin
                fall_r <= (fall_r & ~avs_writedata_in) | (~din_s & prev_r & ~dir_mask);
            end else if (tick) begin
                fall_r <= fall_r | (~din_s & prev_r & ~dir_mask);
            end
            if (wsel && avs_address_in == `TDIO_A_IRQCLR) begin
                ist_r <= (ist_r & ~avs_writedata_in[3:0]) | ev_set;
            end else begin
                ist_r <= ist_r | ev_set;
            end
            irq_out <= |(ist_r & ien_r);
            dio_oe_out <= dir_mask;
            if (due) begin
                dio_out <= f_rdata[31:0] & dir_mask;
            end else begin
                dio_out <= stage_r & dir_mask;
            end
        end
    end

    // ------------------------------------------------------------
    // Avalon slave
    // ------------------------------------------------------------
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_r <= ST_IDLE;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0000_0000;
            dir_r <= {NG{1'b0}};
            stage_r <= {NCH{1'b0}};
            en_r <= 1'b0;
            mode_r <= 1'b0;
            start_r <= 1'b0;
            fclr_r <= 1'b0;
            latin_r <= {NCH{1'b0}};
            latout_r <= {NCH{1'b0}};
            ien_r <= 4'h0;
            hold_r <= 32'h0000_0000;
        end else begin
            fclr_r <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    if (sel) begin
                        st_r <= ST_ACK;
                        avs_waitrequest_out <= 1'b0;
                    end
                end
                ST_ACK: begin
                    st_r <= ST_DONE;
                    avs_waitrequest_out <= 1'b1;
                end
                ST_DONE: begin
                    st_r <= ST_IDLE;
                end
                default: begin
                    st_r <= ST_IDLE;
                    avs_waitrequest_out <= 1'b1;
                end
            endcase
            if (wsel) begin
                case (avs_address_in)
                    `TDIO_A_DIR: dir_r <= dir_wr[NG-1:0];
                    `TDIO_A_DOUT: stage_r <= merge(stage_r, avs_writedata_in, wmask);
                    `TDIO_A_FDATA: hold_r <= avs_writedata_in;
                    `TDIO_A_IRQEN: ien_r <= avs_writedata_in[3:0];
                    `TDIO_A_CTRL: begin
                        // Mode is only taken while the FIFO is off
                        if (!en_r) begin
                            mode_r <= avs_writedata_in[`TDIO_C_MODE];
                        end
                        en_r <= avs_writedata_in[`TDIO_C_EN];
                        start_r <= avs_writedata_in[`TDIO_C_START];
                        fclr_r <= avs_writedata_in[`TDIO_C_CLR];
                        if (avs_writedata_in[`TDIO_C_SYNC]) begin
                            latin_r <= din_s;
                            stage_r <= latout_r;
                        end
                    end
                    `TDIO_A_LATOUT: latout_r <= avs_writedata_in;
                    default: begin
                    end
                endcase
            end
            // Fired pattern becomes the stage so it keeps standing after the pop
            if (due) begin
                stage_r <= f_rdata[NCH-1:0];
            end
            if (rsel) begin
                case (avs_address_in)
                    `TDIO_A_DIR: avs_readdata_out <= {28'h0, dir_r};
                    `TDIO_A_DOUT: avs_readdata_out <= dio_out;
                    `TDIO_A_DIN: avs_readdata_out <= din_s;
                    `TDIO_A_CTRL: avs_readdata_out <= {27'h0, start_r, 2'b00, mode_r, en_r};
                    `TDIO_A_STAT: avs_readdata_out <= {30'h0, f_empty, f_full};
                    `TDIO_A_TIME: avs_readdata_out <= time_r;
                    `TDIO_A_FDATA: avs_readdata_out <= f_rdata[31:0];
                    `TDIO_A_FTIME: avs_readdata_out <= f_rdata[63:32];
                    `TDIO_A_RISE: avs_readdata_out <= rise_r;
                    `TDIO_A_FALL: avs_readdata_out <= fall_r;
                    `TDIO_A_LATIN: avs_readdata_out <= latin_r;
                    `TDIO_A_LATOUT: avs_readdata_out <= latout_r;
                    `TDIO_A_IRQST: avs_readdata_out <= {28'h0, ist_r};
                    `TDIO_A_IRQEN: avs_readdata_out <= {28'h0, ien_r};
                    `TDIO_A_CNT: avs_readdata_out <= {22'h0, f_cnt};
                    default: avs_readdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// >>> tdio_defs.vh
// Notes on behaviour
// - There are 32 channels, and the host sets direction for each group of 8 as a whole.
// - After reset every channel is an input and no output is driven.
// - While monitoring is on, the inputs are sampled for changes at 100 MHz on average.
// - Each change of the sampled input word writes one entry of the word and its time stamp.
// - The FIFO holds at most 511 entries, each a level word paired with a time value.
// - The host reads recorded entries in order and is expected to drain them.
// - Sticky rising-edge and falling-edge flags of the inputs can be queried by the host.
// - In output mode, the device drives the scheduled patterns by itself when their time comes.
// - The host loads pattern and time pairs into the FIFO, and the device takes them as its schedule.
// - The FIFO serves either input recording or output scheduling, chosen before it is enabled.
// - The host sets the output levels and reads back the levels being driven.
// - A trigger on the event input raises an event toward the host.
`ifndef TDIO_DEFS_VH
`define TDIO_DEFS_VH
// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define TDIO_A_DIR 8'h00
`define TDIO_A_DOUT 8'h04
`define TDIO_A_DIN 8'h08
`define TDIO_A_CTRL 8'h0c
`define TDIO_A_STAT 8'h10
`define TDIO_A_TIME 8'h14
`define TDIO_A_FDATA 8'h18
`define TDIO_A_FTIME 8'h1c
`define TDIO_A_RISE 8'h20
`define TDIO_A_FALL 8'h24
`define TDIO_A_LATIN 8'h28
`define TDIO_A_LATOUT 8'h2c
`define TDIO_A_IRQST 8'h30
`define TDIO_A_IRQEN 8'h34
`define TDIO_A_IRQCLR 8'h38
`define TDIO_A_CNT 8'h3c
// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define TDIO_C_EN 0
`define TDIO_C_MODE 1
`define TDIO_C_CLR 2
`define TDIO_C_SYNC 3
`define TDIO_C_START 4
// ------------------------------------------------------------
// Interrupt bits
// ------------------------------------------------------------
`define TDIO_I_EVENT 0
`define TDIO_I_FULL 1
`define TDIO_I_EMPTY 2
`define TDIO_I_EDGE 3
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define TDIO_CLK_MHZ 250
`define TDIO_SAMPLE_MHZ 100
`define TDIO_FIFO_DEPTH 511
`endif

// >>> tdio_sync3.v
`timescale 1ns/1ps
// Three-stage input sampler; output changes once stages two and three agree
module tdio_sync3 #(
    parameter W = 32
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire [W-1:0] d_in,
    output reg [W-1:0] q_out
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    integer i;
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
            s3_r <= {W{1'b0}};
            q_out <= {W{1'b0}};
        end else begin
            s1_r <= d_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_r[i] == s3_r[i]) begin
                    q_out[i] <= s3_r[i];
                end
            end
        end
    end
endmodule

// >>> tdio_fifo.v
`timescale 1ns/1ps
// Pair store: level word and time value per entry
module tdio_fifo #(
    parameter DW = 64,
    parameter DEPTH = 511,
    parameter AW = 9
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire clr_in,
    input wire wr_in,
    input wire [DW-1:0] wdata_in,
    input wire rd_in,
    output wire [DW-1:0] rdata_out,
    output wire full_out,
    output wire empty_out,
    output wire [AW:0] count_out
);
    reg [DW-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0] cnt_r;
    wire do_wr;
    wire do_rd;

    function [AW-1:0] inc;
        input [AW-1:0] p;
        begin
            inc = (p == DEPTH - 1) ? {AW{1'b0}} : p + 1'b1;
        end
    endfunction

    assign full_out = (cnt_r == DEPTH);
    assign empty_out = (cnt_r == {(AW+1){1'b0}});
    assign count_out = cnt_r;
    assign rdata_out = mem[rp_r];
    assign do_wr = wr_in && !full_out;
    assign do_rd = rd_in && !empty_out;

    always @(posedge clk_in) begin
        if (do_wr) begin
            mem[wp_r] <= wdata_in;
        end
    end

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else if (clr_in) begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wp_r <= inc(wp_r);
            end
            if (do_rd) begin
                rp_r <= inc(rp_r);
            end
            if (do_wr && !do_rd) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (do_rd && !do_wr) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// >>> tdio_monitor.sv
`timescale 1ns/1ps
`include "tdio_defs.vh"
module tdio_monitor #(
    parameter NCH = 32
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire [7:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    input wire [NCH-1:0] dio_out,
    input wire [NCH-1:0] dio_oe_out,
    input wire irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // ------------------------------------------------------------
    // Bus steps
    // ------------------------------------------------------------
    sequence s_req;
        $rose(avs_read_in) || $rose(avs_write_in);
    endsequence
    sequence s_done;
        !avs_waitrequest_out;
    endsequence
    sequence s_rd_done(a);
        avs_read_in && !avs_waitrequest_out && avs_address_in == a;
    endsequence
    property p_hold_one;
        $fell(avs_waitrequest_out) |=> avs_waitrequest_out;
    endproperty
    a_hold_one: assert property (p_hold_one)
        else $error("waitrequest low for more than one cycle");
    property p_answer;
        $fell(avs_waitrequest_out) |-> $past(avs_read_in) || $past(avs_write_in);
    endproperty
    a_answer: assert property (p_answer)
        else $error("answer without a request");
    property p_req_bound;
        s_req |-> ##[1:3] s_done;
    endproperty
    a_req_bound: assert property (p_req_bound)
        else $error("request not answered in time");
    property p_oe_group;
        dio_oe_out == {{8{dio_oe_out[24]}}, {8{dio_oe_out[16]}},
            {8{dio_oe_out[8]}}, {8{dio_oe_out[0]}}};
    endproperty
    a_oe_group: assert property (p_oe_group)
        else $error("direction split inside a group");
    property p_dir;
        avs_write_in && !avs_waitrequest_out && avs_address_in == `TDIO_A_DIR
            && avs_byteenable_in == 4'hf |=> dio_oe_out == {{8{$past(avs_writedata_in[3])}},
            {8{$past(avs_writedata_in[2])}}, {8{$past(avs_writedata_in[1])}},
            {8{$past(avs_writedata_in[0])}}};
    endproperty
    a_dir: assert property (p_dir)
        else $error("direction write not applied");
    property p_after_rst;
        $fell(sys_rst_in) |-> dio_oe_out == 32'h0 && !irq_out && avs_waitrequest_out;
    endproperty
    a_after_rst: assert property (p_after_rst)
        else $error("outputs driven after reset");
    property p_unmapped;
        avs_read_in && !avs_waitrequest_out && avs_address_in > `TDIO_A_CNT
            |-> avs_readdata_out == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_dout_rb;
        s_rd_done(`TDIO_A_DOUT) |-> ((avs_readdata_out ^ $past(dio_out))
            & $past(dio_oe_out)) == 32'h0;
    endproperty
    a_dout_rb: assert property (p_dout_rb)
        else $error("output readback differs from driven level");
    property p_stat;
        s_rd_done(`TDIO_A_STAT) |-> avs_readdata_out[1:0] != 2'b11;
    endproperty
    a_stat: assert property (p_stat)
        else $error("full and empty together");
endmodule
bind tdio_top tdio_monitor #(.NCH(NCH)) u_mon (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .dio_out(dio_out),
    .dio_oe_out(dio_oe_out), .irq_out(irq_out));

// >>> tdio_pins.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// External pin model
// ------------------------------------------------------------
module tdio_pins (
    input wire [31:0] stim_in,
    input wire [31:0] drv_in,
    input wire [31:0] oe_in,
    output wire [31:0] pin_out
);
    // Driven groups see their own level, the rest follow the source
    assign pin_out = (drv_in & oe_in) | (stim_in & ~oe_in);
endmodule

// >>> tdio_tb.sv
`timescale 1ns/1ps
`include "tdio_defs.vh"
module testbench;
    logic clk_in, sys_rst_in, avs_read_in, avs_write_in, event_in;
    logic [7:0] avs_address_in;
    logic [3:0] avs_byteenable_in;
    logic [31:0] avs_writedata_in, q, t, stim;
    wire [31:0] avs_readdata_out, dio_in, dio_out, dio_oe_out;
    wire avs_waitrequest_out, irq_out;
    int fail_count, cmp_count;
    tdio_top uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .dio_in(dio_in), .dio_out(dio_out), .dio_oe_out(dio_oe_out), .event_in(event_in),
        .irq_out(irq_out));
    tdio_pins pins (.stim_in(stim), .drv_in(dio_out), .oe_in(dio_oe_out), .pin_out(dio_in));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial begin
        clk_in = 0;
        forever #2 clk_in = ~clk_in;
    end
    task automatic b(input bit w, input [7:0] a, input [31:0] d);
        @(posedge clk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= w;
        avs_read_in <= !w;
        do begin
            @(posedge clk_in);
        end while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_read_in <= 0;
        avs_write_in <= 0;
    endtask
    task automatic chk(input [31:0] g, input [31:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic pulse;
        event_in <= 1;
        repeat (4) @(posedge clk_in);
        event_in <= 0;
        repeat (10) @(posedge clk_in);
    endtask
    task automatic results;
        if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk(dio_oe_out, 0);
        b(0, `TDIO_A_DIR, 0);
        chk(q, 0);
        b(0, 8'h40, 0);
        chk(q, 0);
    endtask
    task automatic t_dir;
        b(1, `TDIO_A_DIR, 32'h5);
        @(posedge clk_in);
        chk(dio_oe_out, 32'h00ff00ff);
        // Upper lanes only: direction byte must stay
        avs_byteenable_in <= 4'he;
        b(1, `TDIO_A_DIR, 0);
        avs_byteenable_in <= 4'hf;
        @(posedge clk_in);
        chk(dio_oe_out, 32'h00ff00ff);
        b(1, `TDIO_A_DOUT, 32'h12345678);
        repeat (2) @(posedge clk_in);
        chk(dio_out & dio_oe_out, 32'h00340078);
        b(0, `TDIO_A_DOUT, 0);
        chk(q & 32'h00ff00ff, 32'h00340078);
        b(0, `TDIO_A_DIN, 0);
        chk(q & 32'hff00ff00, 32'hca00f000);
        b(1, `TDIO_A_LATOUT, 32'h00aa00bb);
        repeat (2) @(posedge clk_in);
        chk(dio_out, 32'h00340078);
        b(1, `TDIO_A_CTRL, 32'h8);
        repeat (2) @(posedge clk_in);
        chk(dio_out, 32'h00aa00bb);
        b(0, `TDIO_A_LATIN, 0);
        chk(q, 32'hca34f078);
        b(1, `TDIO_A_DIR, 0);
    endtask
    task automatic t_edge;
        stim <= 0;
        b(1, `TDIO_A_CTRL, 32'h4);
        b(1, `TDIO_A_RISE, 32'hffffffff);
        b(1, `TDIO_A_FALL, 32'hffffffff);
        b(1, `TDIO_A_CTRL, 32'h1);
        stim <= 32'h3;
        repeat (12) @(posedge clk_in);
        b(0, `TDIO_A_CNT, 0);
        chk(q, 1);
        b(0, `TDIO_A_FDATA, 0);
        chk(q, 3);
        b(0, `TDIO_A_FTIME, 0);
        t = q;
        b(0, `TDIO_A_TIME, 0);
        chk(32'(t < q), 1);
        b(0, `TDIO_A_CNT, 0);
        chk(q, 0);
        b(0, `TDIO_A_RISE, 0);
        chk(q, 3);
        b(0, `TDIO_A_FALL, 0);
        chk(q, 0);
        stim <= 0;
        repeat (12) @(posedge clk_in);
        b(0, `TDIO_A_FALL, 0);
        chk(q, 3);
        b(0, `TDIO_A_FDATA, 0);
        chk(q, 0);
        b(1, `TDIO_A_CTRL, 32'h0);
    endtask
    task automatic t_full;
        b(1, `TDIO_A_CTRL, 32'h4);
        b(1, `TDIO_A_CTRL, 32'h2);
        for (int i = 0; i < `TDIO_FIFO_DEPTH; i++) begin
            b(1, `TDIO_A_FDATA, i);
            b(1, `TDIO_A_FTIME, i);
        end
        b(0, `TDIO_A_STAT, 0);
        chk(q & 32'h3, 32'h1);
        b(1, `TDIO_A_FDATA, 0);
        b(1, `TDIO_A_FTIME, 0);
        b(0, `TDIO_A_CNT, 0);
        chk(q, `TDIO_FIFO_DEPTH);
        b(1, `TDIO_A_CTRL, 32'h4);
        b(0, `TDIO_A_STAT, 0);
        chk(q & 32'h3, 32'h2);
    endtask
    task automatic t_sched;
        b(1, `TDIO_A_DIR, 32'hf);
        b(1, `TDIO_A_CTRL, 32'h2);
        b(1, `TDIO_A_FDATA, 32'ha5a55a5a);
        b(0, `TDIO_A_TIME, 0);
        b(1, `TDIO_A_FTIME, q + 300);
        b(1, `TDIO_A_CTRL, 32'h13);
        repeat (100) @(posedge clk_in);
        chk(32'(dio_out === 32'ha5a55a5a), 0);
        repeat (300) @(posedge clk_in);
        chk(dio_out, 32'ha5a55a5a);
        b(0, `TDIO_A_STAT, 0);
        chk(q & 32'h3, 32'h2);
        b(0, `TDIO_A_DOUT, 0);
        chk(q, 32'ha5a55a5a);
        b(1, `TDIO_A_CTRL, 32'h0);
        b(1, `TDIO_A_DIR, 0);
    endtask
    task automatic t_irq;
        b(1, `TDIO_A_IRQEN, 32'h1);
        pulse;
        chk(irq_out, 1);
        b(0, `TDIO_A_IRQST, 0);
        chk(q & 32'h1, 1);
        b(1, `TDIO_A_IRQCLR, 32'h1);
        repeat (2) @(posedge clk_in);
        chk(irq_out, 0);
        b(1, `TDIO_A_IRQEN, 32'h0);
        pulse;
        chk(irq_out, 0);
        b(1, `TDIO_A_IRQEN, 32'h1);
        repeat (2) @(posedge clk_in);
        chk(irq_out, 1);
        b(1, `TDIO_A_IRQCLR, 32'h1);
    endtask
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        sys_rst_in = 1;
        avs_read_in = 0;
        avs_write_in = 0;
        avs_address_in = 0;
        avs_writedata_in = 0;
        avs_byteenable_in = 4'hf;
        event_in = 0;
        stim = 32'hcafef00d;
        fail_count = 0;
        cmp_count = 0;
        repeat (20) @(posedge clk_in);
        sys_rst_in <= 0;
        t_reset;
        t_dir;
        t_edge;
        t_full;
        t_sched;
        t_irq;
        results;
    end
    initial begin
        repeat (30000) @(posedge clk_in);
        fail_count++;
        results;
    end
endmodule
